// ---- core/adc_conversion_control.sv ----
// Conversion control: AXI4-Lite register file, conversion clock, sequencer,
// result shaping and window monitor for an external analog core.
// Assumes the core follows CORE_CLK_OUT/SAMPLE_OUT and holds its sample.
// What this block does
// [R1] Sample phase lasts sample length plus one half conversion periods.
// [R2] Reserved bits always read back as zero.
// [R3] Divider codes 0..7 give conversion clock divide by 4..512.
// [R4] Divider field writes are ignored while the converter is enabled.
// [R5] Width code picks 12, 10 or 8 bit results; the 16-bit code gives 12 bits.
// [R6] Width setting only accepted while the converter is disabled.
// [R7] Correction applies offset and gain, lengthening the conversion.
// [R8] Free-running restarts on completion; otherwise one conversion each.
// [R9] Left alignment puts result at top; right alignment by default.
// [R10] Differential select converts positive minus negative input.
// [R11] Mode bits change only while the converter is disabled.
// [R12] Window modes: off, above, below, inside, outside; 5..7 reserved.
// [R13] Start bit begins a conversion, cleared by hardware on start.
// [R14] Writing zero to start or flush does nothing.
// [R15] Flush restarts conversion clock next edge and aborts conversions.
// [R16] Flush bit reads set until the flush has finished.
// [R17] After flush, pending or running work restarts afresh.
// [R18] Synchronized registers land on a conversion clock edge; lockable.
// [R19] Input register: gain 27:24, negative 12:8, positive 4:0.
// [R20] Scan position steps by one after each conversion in scan mode, except the last of a scan, which wraps it back.
// [R21] A scan covers scan count plus one inputs.
// [R22] Sync pending flag stays set while a synchronized write lands.
// [R23] Window flag raised when a result meets the compare condition.
// [R24] Software disables before mode changes and polls the sync flag.
//
// Chosen here: the AXI4-Lite register port.
`timescale 1ns/1ns
module adc_conversion_control (
	input  wire logic                   SYS_CLK_IN,
	input  wire logic                   RST_IN,
	input  wire adc_ctl_pkg::axil_req_s AXI_REQ_IN,
	output adc_ctl_pkg::axil_rsp_s      AXI_RSP_OUT,
	input  wire logic                   WRITE_LOCK_IN,
	input  wire adc_ctl_pkg::raw_t      CORE_DATA_IN,
	output logic                        CORE_CLK_OUT,
	output logic                        SAMPLE_OUT,
	output adc_ctl_pkg::core_cfg_s      CORE_CFG_OUT,
	output adc_ctl_pkg::result_t        RESULT_OUT,
	output logic                        RESULT_VALID_OUT,
	output logic                        WINDOW_HIT_OUT
);
	import adc_ctl_pkg::*;

	logic        aw_hold_q, w_hold_q, bvalid_q, rvalid_q;
	addr_t       awaddr_q, rd_addr_q;
	word_t       wdata_q, rdata_q;
	logic [3:0]  wstrb_q;
	logic [1:0]  bresp_q;
	logic        run_en_q, start_q, flush_q, flush_run_q, win_flag_q;
	logic [5:0]  samp_len_q, cnt_q, cnt_d;
	word_t       mode_stage_q, mode_q, input_stage_q, input_q, cal_q;
	logic [2:0]  win_stage_q;
	win_mode_e   win_q;
	logic [3:0]  pend_q, pend_set, scan_step_q;
	result_t     winlo_q, winhi_q, result_q;
	conv_state_e state_q, state_d;
	raw_t        core_s1_q, core_s2_q, core_s3_q, core_q;
	logic        result_valid_q, win_hit_q, sample_q;
	core_cfg_s   cfg_q;
	logic        half_tick;

	// Bus handshake and decode
	wire logic  awready_w = ~aw_hold_q & ~bvalid_q;
	wire logic  wready_w  = ~w_hold_q & ~bvalid_q;
	wire logic  wr_fire   = aw_hold_q & w_hold_q & ~bvalid_q;
	wire logic  rd_take   = AXI_REQ_IN.arvalid & ~rvalid_q;
	wire word_t wr_bm     = {{8{wstrb_q[3]}}, {8{wstrb_q[2]}},
		{8{wstrb_q[1]}}, {8{wstrb_q[0]}}};
	wire logic  sel_run    = awaddr_q == ADDR_RUN;
	wire logic  sel_samp   = awaddr_q == ADDR_SAMPLE;
	wire logic  sel_mode   = awaddr_q == ADDR_MODE;
	wire logic  sel_win    = awaddr_q == ADDR_WIN;
	wire logic  sel_trig   = awaddr_q == ADDR_TRIG;
	wire logic  sel_input  = awaddr_q == ADDR_INPUT;
	wire logic  sel_winlo  = awaddr_q == ADDR_WINLO;
	wire logic  sel_winhi  = awaddr_q == ADDR_WINHI;
	wire logic  sel_cal    = awaddr_q == ADDR_CAL;
	wire logic  sel_status = awaddr_q == ADDR_STATUS;
	wire logic  sel_prot   = sel_run | sel_samp | sel_mode | sel_win
		| sel_trig | sel_input | sel_winlo | sel_winhi | sel_cal;
	// Locked writes to protected registers are refused
	wire logic  wr_ok  = wr_fire & sel_prot & ~WRITE_LOCK_IN; // R18
	wire logic  wr_st  = wr_fire & sel_status;
	wire logic  wr_acc = (sel_prot & ~WRITE_LOCK_IN) | sel_status;

	function automatic word_t merge(input word_t old, input word_t mask);
		merge = ((old & ~wr_bm) | (wdata_q & wr_bm)) & mask; // R2
	endfunction

	wire word_t wd_trig  = wdata_q & wr_bm & MASK_TRIG;
	// Whole mode register is enable-protected
	wire logic  mode_wr  = wr_ok & sel_mode & ~run_en_q; // R4 R6 R11
	wire logic  start_set = wr_ok & sel_trig & wd_trig[TRIG_START_BIT];
	wire logic  flush_set = wr_ok & sel_trig & wd_trig[TRIG_FLUSH_BIT];
	wire logic  sync_busy = |pend_q; // R22

	// Field views of the applied registers
	wire logic [2:0] presc_w = mode_q[MODE_PRESC_LSB +: 3];
	wire res_sel_e res_w  = res_sel_e'(mode_q[MODE_RES_LSB +: 2]);
	wire logic corr_en    = mode_q[MODE_CORR_BIT];
	wire logic free_run   = mode_q[MODE_FREE_BIT];
	wire logic align_msb  = mode_q[MODE_ALIGN_BIT];
	wire logic [3:0] scan_pos = input_q[IN_SCANPOS_LSB +: 4];
	wire logic [3:0] scan_cnt = input_q[IN_SCANCNT_LSB +: 4];

	// Sequencer timing
	wire logic flush_go   = flush_q & ~flush_run_q;
	wire logic flush_done = half_tick & flush_run_q;
	wire logic conv_begin = half_tick & run_en_q & ~flush_go
		& (state_q == ST_IDLE) & start_q;
	wire logic [5:0] res_bits = (res_w == RES_10BIT) ? BITS_10 :
		(res_w == RES_8BIT) ? BITS_8 : BITS_12; // R5
	wire logic [5:0] conv_last = 6'({res_bits[4:0], 1'b0}
		+ (corr_en ? CORR_HALVES : 6'h00) - 6'h01); // R7
	wire logic finish = half_tick & run_en_q & ~flush_go
		& (state_q == ST_CONVERT) & (cnt_q == conv_last);
	wire logic resume = flush_go & (state_q != ST_IDLE); // R17

	// Scan stepping wraps back after scan count plus one inputs
	wire logic scan_adv = finish & (scan_cnt != 4'h0); // R20
	wire logic scan_end = scan_step_q == scan_cnt; // R21
	wire logic [3:0] next_pos = scan_end ? 4'(scan_pos - scan_cnt)
		: 4'(scan_pos + 4'h1);

	// Result correction and shaping
	wire logic signed [12:0] offs_diff = $signed({1'b0, core_q})
		- $signed({1'b0, cal_q[CAL_OFFS_LSB +: 12]});
	wire logic signed [25:0] gain_prod = offs_diff
		* $signed({1'b0, cal_q[11:0]});
	wire logic signed [25:0] scaled = gain_prod >>> GAIN_FRAC;
	wire raw_t corr_val = scaled[25] ? 12'h000 :
		(|scaled[24:12]) ? 12'hFFF : scaled[11:0];
	wire raw_t conv_val = corr_en ? corr_val : core_q; // R7
	wire logic [5:0] rsh = 6'(BITS_12 - res_bits);
	wire result_t res_right = result_t'({4'h0, conv_val} >> rsh);
	wire logic [5:0] lsh = 6'(6'h10 - res_bits);
	wire result_t res_final = align_msb ? result_t'(res_right << lsh)
		: res_right; // R9

	// Window compare on the shaped result
	wire logic above_lo = res_final > winlo_q;
	wire logic below_hi = res_final < winhi_q;
	wire logic win_hit  = ((win_q == WIN_ABOVE) & above_lo)
		| ((win_q == WIN_BELOW) & below_hi)
		| ((win_q == WIN_INSIDE) & above_lo & below_hi)
		| ((win_q == WIN_OUTSIDE) & ~(above_lo & below_hi)); // R12

	// Read decode
	wire addr_t ra = AXI_REQ_IN.araddr;
	wire word_t rd_word =
		(ra == ADDR_RUN)    ? {31'h0, run_en_q} :
		(ra == ADDR_SAMPLE) ? {26'h0, samp_len_q} :
		(ra == ADDR_MODE)   ? mode_stage_q :
		(ra == ADDR_WIN)    ? {29'h0, win_stage_q} :
		(ra == ADDR_TRIG)   ? {30'h0, start_q, flush_q} : // R16
		(ra == ADDR_INPUT)  ? input_stage_q :
		(ra == ADDR_WINLO)  ? {16'h0, winlo_q} :
		(ra == ADDR_WINHI)  ? {16'h0, winhi_q} :
		(ra == ADDR_CAL)    ? cal_q :
		(ra == ADDR_STATUS) ? {29'h0, state_q != ST_IDLE, win_flag_q,
			sync_busy} :
		(ra == ADDR_RESULT) ? {16'h0, result_q} : 32'h0;
	wire logic rd_hit = (ra == ADDR_RUN) | (ra == ADDR_SAMPLE)
		| (ra == ADDR_MODE) | (ra == ADDR_WIN) | (ra == ADDR_TRIG)
		| (ra == ADDR_INPUT) | (ra == ADDR_WINLO) | (ra == ADDR_WINHI)
		| (ra == ADDR_CAL) | (ra == ADDR_STATUS) | (ra == ADDR_RESULT);
	logic [1:0] rresp_q;

	assign pend_set = {wr_ok & sel_input, wr_ok & sel_trig
		& (|wd_trig), wr_ok & sel_win, mode_wr}; // R18

	assign AXI_RSP_OUT = '{awready: awready_w, wready: wready_w,
		bvalid: bvalid_q, bresp: bresp_q, arready: ~rvalid_q,
		rvalid: rvalid_q, rdata: rdata_q, rresp: rresp_q};
	assign SAMPLE_OUT       = sample_q;
	assign CORE_CFG_OUT     = cfg_q;
	assign RESULT_OUT       = result_q;
	assign RESULT_VALID_OUT = result_valid_q;
	assign WINDOW_HIT_OUT   = win_hit_q;

	conv_clock_divider u_div (
		.clk_in        (SYS_CLK_IN),
		.rst_in        (RST_IN),
		.restart_in    (flush_go), // R15
		.code_in       (presc_w),
		.half_tick_out (half_tick),
		.conv_clk_out  (CORE_CLK_OUT)
	);

	always_ff @(posedge SYS_CLK_IN) begin
		if (RST_IN) begin
			aw_hold_q <= 1'b0;
			w_hold_q  <= 1'b0;
			bvalid_q  <= 1'b0;
			bresp_q   <= RESP_OKAY;
		end else begin
			if (AXI_REQ_IN.awvalid & awready_w) begin
				aw_hold_q <= 1'b1;
				awaddr_q  <= AXI_REQ_IN.awaddr;
			end else if (wr_fire) begin
				aw_hold_q <= 1'b0;
			end
			if (AXI_REQ_IN.wvalid & wready_w) begin
				w_hold_q <= 1'b1;
				wdata_q  <= AXI_REQ_IN.wdata;
				wstrb_q  <= AXI_REQ_IN.wstrb;
			end else if (wr_fire) begin
				w_hold_q <= 1'b0;
			end
			if (wr_fire) begin
				bvalid_q <= 1'b1;
				bresp_q  <= wr_acc ? RESP_OKAY : RESP_SLVERR;
			end else if (AXI_REQ_IN.bready) begin
				bvalid_q <= 1'b0;
			end
		end
	end

	always_ff @(posedge SYS_CLK_IN) begin
		if (RST_IN) begin
			rvalid_q  <= 1'b0;
			rdata_q   <= 32'h0;
			rresp_q   <= RESP_OKAY;
			rd_addr_q <= ADDR_RUN;
		end else if (rd_take) begin
			rvalid_q  <= 1'b1;
			rdata_q   <= rd_word;
			rresp_q   <= rd_hit ? RESP_OKAY : RESP_SLVERR;
			rd_addr_q <= ra;
		end else if (AXI_REQ_IN.rready) begin
			rvalid_q <= 1'b0;
		end
	end

	// Software-written registers and staging
	always_ff @(posedge SYS_CLK_IN) begin
		if (RST_IN) begin
			run_en_q     <= 1'b0;
			samp_len_q   <= 6'h00;
			mode_stage_q <= 32'h0;
			win_stage_q  <= 3'h0;
			winlo_q      <= 16'h0000;
			winhi_q      <= 16'h0000;
			cal_q        <= RST_CAL;
		end else if (wr_ok) begin
			if (sel_run)
				run_en_q <= 1'(merge({31'h0, run_en_q}, MASK_RUN)
					>> RUN_EN_BIT);
			if (sel_samp)
				samp_len_q <= 6'(merge({26'h0, samp_len_q}, MASK_SAMPLE));
			if (mode_wr)
				mode_stage_q <= merge(mode_stage_q, MASK_MODE);
			if (sel_win)
				win_stage_q <= 3'(merge({29'h0, win_stage_q}, MASK_WIN));
			if (sel_winlo)
				winlo_q <= 16'(merge({16'h0, winlo_q}, MASK_LIMIT));
			if (sel_winhi)
				winhi_q <= 16'(merge({16'h0, winhi_q}, MASK_LIMIT));
			if (sel_cal)
				cal_q <= merge(cal_q, MASK_CAL);
		end
	end

	// Staged values land on a conversion clock edge
	always_ff @(posedge SYS_CLK_IN) begin
		if (RST_IN) begin
			pend_q <= 4'h0;
			mode_q <= 32'h0;
			win_q  <= WIN_OFF;
		end else begin
			pend_q <= (pend_q & ~{4{half_tick}}) | pend_set; // R22
			if (half_tick & pend_q[PEND_MODE])
				mode_q <= mode_stage_q; // R18
			if (half_tick & pend_q[PEND_WIN])
				win_q <= win_mode_e'(win_stage_q);
		end
	end

	// Input select with scan stepping; a landing write wins
	always_ff @(posedge SYS_CLK_IN) begin
		if (RST_IN) begin
			input_stage_q <= 32'h0;
			input_q       <= 32'h0;
			scan_step_q   <= 4'h0;
		end else begin
			if (wr_ok & sel_input)
				input_stage_q <= merge(input_stage_q, MASK_INPUT); // R19
			else if (scan_adv & ~pend_q[PEND_INPUT])
				input_stage_q[IN_SCANPOS_LSB +: 4] <= next_pos;
			if (half_tick & pend_q[PEND_INPUT]) begin
				input_q     <= input_stage_q;
				scan_step_q <= 4'h0;
			end else if (scan_adv) begin
				input_q[IN_SCANPOS_LSB +: 4] <= next_pos; // R20
				scan_step_q <= scan_end ? 4'h0 : 4'(scan_step_q + 4'h1);
			end
		end
	end

	// Trigger bits: setting wins over the hardware clear
	always_ff @(posedge SYS_CLK_IN) begin
		if (RST_IN) begin
			start_q     <= 1'b0;
			flush_q     <= 1'b0;
			flush_run_q <= 1'b0;
		end else begin
			start_q <= start_set | resume | (start_q & ~conv_begin); // R13 R14
			flush_q <= flush_set | (flush_q & ~flush_done); // R16
			flush_run_q <= (flush_run_q | flush_go) & ~flush_done;
		end
	end

	always_comb begin
		state_d = state_q;
		cnt_d   = cnt_q;
		if (flush_go | ~run_en_q) begin
			state_d = ST_IDLE; // R15
			cnt_d   = 6'h00;
		end else if (half_tick) begin
			unique case (state_q)
				ST_IDLE: begin
					if (start_q) begin
						state_d = ST_SAMPLE;
						cnt_d   = 6'h00;
					end
				end
				ST_SAMPLE: begin
					if (cnt_q == samp_len_q) begin // R1
						state_d = ST_CONVERT;
						cnt_d   = 6'h00;
					end else begin
						cnt_d = 6'(cnt_q + 6'h01);
					end
				end
				ST_CONVERT: begin
					if (cnt_q == conv_last) begin
						state_d = free_run ? ST_SAMPLE : ST_IDLE; // R8
						cnt_d   = 6'h00;
					end else begin
						cnt_d = 6'(cnt_q + 6'h01);
					end
				end
				default: state_d = ST_IDLE;
			endcase
		end
	end

	always_ff @(posedge SYS_CLK_IN) begin
		if (RST_IN) begin
			state_q <= ST_IDLE;
			cnt_q   <= 6'h00;
		end else begin
			state_q <= state_d;
			cnt_q   <= cnt_d;
		end
	end

	// Core sample crosses in: taken once stages two and three agree
	always_ff @(posedge SYS_CLK_IN) begin
		if (RST_IN) begin
			core_s1_q <= 12'h000;
			core_s2_q <= 12'h000;
			core_s3_q <= 12'h000;
			core_q    <= 12'h000;
		end else begin
			core_s1_q <= CORE_DATA_IN;
			core_s2_q <= core_s1_q;
			core_s3_q <= core_s2_q;
			if (core_s2_q == core_s3_q)
				core_q <= core_s3_q;
		end
	end

	always_ff @(posedge SYS_CLK_IN) begin
		if (RST_IN) begin
			result_q       <= 16'h0000;
			result_valid_q <= 1'b0;
			win_hit_q      <= 1'b0;
			win_flag_q     <= 1'b0;
			sample_q       <= 1'b0;
			cfg_q          <= '0;
		end else begin
			if (finish)
				result_q <= res_final;
			result_valid_q <= finish;
			win_hit_q      <= finish & win_hit; // R23
			win_flag_q     <= (finish & win_hit) | (win_flag_q
				& ~(wr_st & wdata_q[STAT_WIN_BIT] & wstrb_q[0]));
			sample_q       <= state_d == ST_SAMPLE;
			cfg_q.pos_sel  <= 5'(input_q[IN_POS_LSB +: 5]
				+ {1'b0, scan_pos});
			cfg_q.neg_sel  <= input_q[IN_NEG_LSB +: 5];
			cfg_q.gain     <= input_q[IN_GAIN_LSB +: 4];
			cfg_q.diff     <= mode_q[MODE_DIFF_BIT]; // R10
			cfg_q.width    <= res_w;
			cfg_q.correct  <= corr_en;
		end
	end

	// Checks
	logic [15:0] samp_cyc_q, tick_gap_q;
	wire logic [15:0] half_per = 16'h0002 << presc_w;
	wire logic [15:0] samp_span = 16'((16'({10'h000, samp_len_q})
		+ 16'h0001) * half_per);
	always_ff @(posedge SYS_CLK_IN) begin
		if (RST_IN | (state_q != ST_SAMPLE))
			samp_cyc_q <= 16'h0000;
		else
			samp_cyc_q <= 16'(samp_cyc_q + 16'h0001);
		if (RST_IN | half_tick | flush_go)
			tick_gap_q <= 16'h0000;
		else
			tick_gap_q <= 16'(tick_gap_q + 16'h0001);
	end

	default clocking cb @(posedge SYS_CLK_IN); endclocking
	default disable iff (RST_IN);

	chk_sample_span: assert property ( // R1
		(state_q == ST_SAMPLE && state_d == ST_CONVERT)
		|-> 16'(samp_cyc_q + 16'h0001) == samp_span)
		else $error("sample phase length wrong");
	chk_divider_period: assert property ( // R3
		half_tick && !$past(flush_go) && $stable(presc_w)
		|-> 16'(tick_gap_q + 16'h0001) == half_per)
		else $error("conversion clock half period wrong");
	chk_mode_locked: assert property ( // R4
		run_en_q && wr_fire && sel_mode |=> $stable(mode_stage_q))
		else $error("mode changed while enabled");
	chk_reserved_zero: assert property ( // R2
		rvalid_q && rd_addr_q == ADDR_INPUT |-> !(|(rdata_q & ~MASK_INPUT)))
		else $error("reserved input bits read nonzero");
	chk_start_begins: assert property ( // R13
		conv_begin && !start_set
		|=> state_q == ST_SAMPLE && !start_q)
		else $error("start not consumed on conversion begin");
	chk_start_zero: assert property ( // R14
		wr_ok && sel_trig && !wd_trig[TRIG_START_BIT] && !start_q
		&& !flush_go |=> !start_q)
		else $error("zero write raised start");
	chk_flush_clears: assert property ( // R16
		flush_go |=> flush_q ##[1:300] !flush_run_q)
		else $error("flush did not finish");
	chk_flush_resume: assert property ( // R17
		flush_go && state_q != ST_IDLE |=> start_q && state_q == ST_IDLE)
		else $error("flush did not abort and resume");
	chk_free_run: assert property ( // R8
		finish && free_run |=> state_q == ST_SAMPLE ##1 RESULT_VALID_OUT
		== 1'b0)
		else $error("free-running did not relaunch");
	chk_sync_flag: assert property ( // R22
		wr_ok && sel_win |=> sync_busy ##[1:300] !pend_q[PEND_WIN])
		else $error("sync flag not held or never cleared");
	chk_lock_refused: assert property ( // R18
		wr_fire && WRITE_LOCK_IN && sel_samp
		|=> $stable(samp_len_q) && bresp_q == RESP_SLVERR)
		else $error("locked write not refused");
	chk_window_inside: assert property ( // R12
		finish && win_q == WIN_INSIDE && $stable(winlo_q) |=> WINDOW_HIT_OUT
		== (RESULT_OUT > winlo_q && RESULT_OUT < winhi_q))
		else $error("inside window compare wrong");

	cov_free_run: cover property (RESULT_VALID_OUT ##[1:900] RESULT_VALID_OUT);
	cov_flush_busy: cover property (flush_go && state_q == ST_CONVERT);
	cov_window_hit: cover property (WINDOW_HIT_OUT);
	cov_scan_wrap: cover property (scan_adv && scan_end);
endmodule

// ---- core/adc_ctl_pkg.sv ----
// Package: register map, field layout, modes and carriers of the
// conversion control block. Assumes a 32-bit AXI4-Lite register bus.
package adc_ctl_pkg;
	localparam int DATA_W = 32;
	localparam int ADDR_W = 8;
	typedef logic [DATA_W-1:0] word_t;
	typedef logic [ADDR_W-1:0] addr_t;
	typedef logic [11:0]       raw_t;
	typedef logic [15:0]       result_t;
	// Register indices; each byte address is four times its index
	localparam addr_t IDX_SAMPLE  = 8'h03;
	localparam addr_t IDX_MODE    = 8'h04;
	localparam addr_t IDX_WIN     = 8'h08;
	localparam addr_t IDX_TRIG    = 8'h0C;
	localparam addr_t IDX_INPUT   = 8'h10;
	localparam addr_t ADDR_SAMPLE = {IDX_SAMPLE[5:0], 2'b00};
	localparam addr_t ADDR_MODE   = {IDX_MODE[5:0], 2'b00};
	localparam addr_t ADDR_WIN    = {IDX_WIN[5:0], 2'b00};
	localparam addr_t ADDR_TRIG   = {IDX_TRIG[5:0], 2'b00};
	localparam addr_t ADDR_INPUT  = {IDX_INPUT[5:0], 2'b00};
	localparam addr_t ADDR_RUN    = 8'h00;
	localparam addr_t ADDR_WINLO  = 8'h50;
	localparam addr_t ADDR_WINHI  = 8'h54;
	localparam addr_t ADDR_CAL    = 8'h58;
	localparam addr_t ADDR_STATUS = 8'h5C;
	localparam addr_t ADDR_RESULT = 8'h60;
	localparam word_t MASK_RUN    = 32'h00000001;
	localparam word_t MASK_SAMPLE = 32'h0000003F;
	localparam word_t MASK_MODE   = 32'h0000073F;
	localparam word_t MASK_WIN    = 32'h00000007;
	localparam word_t MASK_TRIG   = 32'h00000003;
	localparam word_t MASK_INPUT  = 32'h0FFF1F1F;
	localparam word_t MASK_LIMIT  = 32'h0000FFFF;
	localparam word_t MASK_CAL    = 32'h0FFF0FFF;
	localparam word_t RST_CAL     = 32'h00000800;
	localparam int MODE_PRESC_LSB = 8;
	localparam int MODE_RES_LSB   = 4;
	localparam int MODE_CORR_BIT  = 3;
	localparam int MODE_FREE_BIT  = 2;
	localparam int MODE_ALIGN_BIT = 1;
	localparam int MODE_DIFF_BIT  = 0;
	localparam int IN_GAIN_LSB    = 24;
	localparam int IN_SCANPOS_LSB = 20;
	localparam int IN_SCANCNT_LSB = 16;
	localparam int IN_NEG_LSB     = 8;
	localparam int IN_POS_LSB     = 0;
	localparam int TRIG_START_BIT = 1;
	localparam int TRIG_FLUSH_BIT = 0;
	localparam int STAT_SYNC_BIT  = 0;
	localparam int STAT_WIN_BIT   = 1;
	localparam int STAT_BUSY_BIT  = 2;
	localparam int RUN_EN_BIT     = 0;
	localparam int CAL_OFFS_LSB   = 16;
	localparam int GAIN_FRAC      = 11;
	localparam int PEND_MODE      = 0;
	localparam int PEND_WIN       = 1;
	localparam int PEND_TRIG      = 2;
	localparam int PEND_INPUT     = 3;
	// Conversion length in conversion-clock periods; CORR_HALVES in half periods
	localparam logic [5:0] BITS_12     = 6'h0C;
	localparam logic [5:0] BITS_10     = 6'h0A;
	localparam logic [5:0] BITS_8      = 6'h08;
	localparam logic [5:0] CORR_HALVES = 6'h06;
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	typedef enum logic [1:0] {
		RES_12BIT = 2'b00, RES_16BIT = 2'b01,
		RES_10BIT = 2'b10, RES_8BIT = 2'b11
	} res_sel_e;
	typedef enum logic [2:0] {
		WIN_OFF = 3'b000, WIN_ABOVE = 3'b001, WIN_BELOW = 3'b010,
		WIN_INSIDE = 3'b011, WIN_OUTSIDE = 3'b100
	} win_mode_e;
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00, ST_SAMPLE = 2'b01, ST_CONVERT = 2'b10
	} conv_state_e;
	typedef struct packed {
		logic awvalid; addr_t awaddr; logic wvalid; word_t wdata;
		logic [3:0] wstrb; logic bready; logic arvalid; addr_t araddr;
		logic rready;
	} axil_req_s;
	typedef struct packed {
		logic awready; logic wready; logic bvalid; logic [1:0] bresp;
		logic arready; logic rvalid; word_t rdata; logic [1:0] rresp;
	} axil_rsp_s;
	typedef struct packed {
		logic [4:0] pos_sel; logic [4:0] neg_sel; logic [3:0] gain;
		logic diff; res_sel_e width; logic correct;
	} core_cfg_s;
endpackage

// ---- core/conv_clock_divider.sv ----
// Conversion clock divider: half-period tick and clock level.
// Assumes the code is only changed between ticks by the owner.
`timescale 1ns/1ns
module conv_clock_divider (
	input  wire logic       clk_in,
	input  wire logic       rst_in,
	input  wire logic       restart_in,
	input  wire logic [2:0] code_in,
	output logic            half_tick_out,
	output logic            conv_clk_out
);
	logic [8:0] count_q;
	logic       clk_q;
	wire  logic [8:0] last_w = 9'((9'h002 << code_in) - 9'h001);

	// Half period is 2^(code+1) cycles, full period 2^(code+2)
	assign half_tick_out = (count_q == last_w) & ~restart_in; // R3
	assign conv_clk_out  = clk_q;

	always_ff @(posedge clk_in) begin
		if (rst_in | restart_in) begin
			count_q <= 9'h000;
			clk_q   <= 1'b0;
		end else if (half_tick_out) begin
			count_q <= 9'h000;
			clk_q   <= ~clk_q;
		end else begin
			count_q <= 9'(count_q + 9'h001);
		end
	end
endmodule

// ---- verif/front_model.sv ----
// Front end model: holds the input level taken when sampling ends.
// Assumes the sample phase output of the conversion control block.
`timescale 1ns/1ns
module front_model (
	input  wire logic              clk_in,
	input  wire logic              sample_in,
	input  wire adc_ctl_pkg::raw_t level_in,
	output adc_ctl_pkg::raw_t      data_out
);
	import adc_ctl_pkg::*;
	raw_t held_q;
	logic smp_q;
	always_ff @(posedge clk_in) begin
		smp_q <= sample_in;
		if (smp_q && !sample_in)
			held_q <= level_in;
	end
	// Unsettled while sampling, so show the inverse
	assign data_out = sample_in ? ~held_q : held_q;
endmodule

// ---- verif/tb_adc_conversion_control.sv ----
// Testbench: register map, protection and conversions of the block.
// Assumes the package and the front end model are compiled first.
`timescale 1ns/1ns
module tb_adc_conversion_control;
	import adc_ctl_pkg::*;
	logic      clk;
	logic      rst;
	logic      lock;
	logic      vld;
	logic      hit;
	logic      smp;
	logic      cclk;
	core_cfg_s cfg;
	axil_req_s req;
	axil_rsp_s rsp;
	raw_t      core;
	raw_t      level;
	result_t   res;
	word_t     d;
	logic [1:0] r;
	int        fails = 0;
	int        checked = 0;
	int        cyc = 0;
	adc_conversion_control dut_u (.SYS_CLK_IN(clk), .RST_IN(rst),
		.AXI_REQ_IN(req), .AXI_RSP_OUT(rsp), .WRITE_LOCK_IN(lock),
		.CORE_DATA_IN(core), .CORE_CLK_OUT(cclk), .SAMPLE_OUT(smp),
		.CORE_CFG_OUT(cfg), .RESULT_OUT(res), .RESULT_VALID_OUT(vld),
		.WINDOW_HIT_OUT(hit));
	front_model fe_u (.clk_in(clk), .sample_in(smp), .level_in(level),
		.data_out(core));
	initial begin
		clk = 0;
		forever #5 clk = ~clk;
	end
	task automatic finish_test();
		if (fails == 0 && checked > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			fails++;
			finish_test();
		end
	end
	task automatic cmp_w(input word_t g, input word_t e);
		checked++;
		if (g !== e) begin
			fails++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task automatic wr(input addr_t a, input word_t v, input logic [1:0] er);
		logic aw;
		logic w;
		aw = 1;
		w = 1;
		req.awvalid <= 1;
		req.awaddr <= a;
		req.wvalid <= 1;
		req.wdata <= v;
		req.wstrb <= 4'hF;
		req.bready <= 1;
		while (aw || w) begin
			@(negedge clk);
			aw = aw && !rsp.awready;
			w = w && !rsp.wready;
			@(posedge clk);
			req.awvalid <= aw;
			req.wvalid <= w;
		end
		do @(negedge clk); while (rsp.bvalid !== 1'b1);
		cmp_w(word_t'(rsp.bresp), word_t'(er));
		@(posedge clk);
	endtask
	task automatic rd(input addr_t a);
		logic ar;
		ar = 1;
		req.arvalid <= 1;
		req.araddr <= a;
		req.rready <= 1;
		while (ar) begin
			@(negedge clk);
			ar = !rsp.arready;
			@(posedge clk);
			req.arvalid <= ar;
		end
		do @(negedge clk); while (rsp.rvalid !== 1'b1);
		d = rsp.rdata;
		r = rsp.rresp;
		@(posedge clk);
	endtask
	task automatic rc(input addr_t a, input word_t e);
		rd(a);
		cmp_w(d, e);
	endtask
	// Conversion clock period in system cycles, rising edge to rising edge
	task automatic t_clk(input int e);
		int n;
		n = 0;
		do @(negedge clk); while (cclk !== 1'b0);
		do @(negedge clk); while (cclk !== 1'b1);
		do begin @(negedge clk); n++; end while (cclk !== 1'b0);
		do begin @(negedge clk); n++; end while (cclk !== 1'b1);
		cmp_w(word_t'(n), word_t'(e));
	endtask
	task automatic t_regs();
		rc(ADDR_MODE, 32'h0);
		wr(ADDR_MODE, 32'hFFFFFFFF, RESP_OKAY);
		rc(ADDR_MODE, 32'h0000073F);
		wr(ADDR_INPUT, 32'hFFFFFFFF, RESP_OKAY);
		rc(ADDR_INPUT, 32'h0FFF1F1F);
		wr(ADDR_SAMPLE, 32'hFFFFFFFF, RESP_OKAY);
		rc(ADDR_SAMPLE, 32'h3F);
		lock <= 1;
		wr(ADDR_SAMPLE, 32'h0, RESP_SLVERR);
		lock <= 0;
		rc(ADDR_SAMPLE, 32'h3F);
		rc(8'h44, 32'h0);
		cmp_w(word_t'(r), word_t'(RESP_SLVERR));
		wr(ADDR_INPUT, 32'h0, RESP_OKAY);
		wr(ADDR_SAMPLE, 32'h0, RESP_OKAY);
		wr(ADDR_RUN, 32'h1, RESP_OKAY);
		wr(ADDR_MODE, 32'h0, RESP_OKAY);
		rc(ADDR_MODE, 32'h0000073F);
	endtask
	task automatic conv(input word_t m, input word_t er, input logic eh,
		input logic fl);
		wr(ADDR_RUN, 32'h0, RESP_OKAY);
		wr(ADDR_MODE, m, RESP_OKAY);
		wr(ADDR_RUN, 32'h1, RESP_OKAY);
		do rd(ADDR_STATUS); while (d[STAT_SYNC_BIT] !== 1'b0);
		wr(ADDR_TRIG, 32'h2, RESP_OKAY);
		if (fl) begin
			// Flush lands mid-conversion; the aborted one must restart
			repeat (8) @(posedge clk);
			wr(ADDR_TRIG, 32'h1, RESP_OKAY);
		end
		do @(negedge clk); while (vld !== 1'b1);
		cmp_w(word_t'(res), er);
		cmp_w(word_t'(hit), word_t'(eh));
		cmp_w(word_t'(cfg.diff), word_t'(m[MODE_DIFF_BIT]));
		if (m[MODE_FREE_BIT]) begin
			do @(negedge clk); while (vld !== 1'b1);
			cmp_w(word_t'(res), er);
		end
		@(posedge clk);
		rc(ADDR_TRIG, 32'h0);
	endtask
	initial begin
		rst = 1;
		lock = 0;
		level = 12'h0;
		req = '0;
		repeat (20) @(posedge clk);
		rst <= 0;
		t_regs();
		t_clk(512);
		level <= 12'hABC;
		wr(ADDR_WINLO, 32'h100, RESP_OKAY);
		wr(ADDR_WIN, 32'h1, RESP_OKAY);
		conv(32'h0, 32'hABC, 1'b1, 1'b0);
		conv(32'h2, 32'hABC0, 1'b1, 1'b0);
		conv(32'h20, 32'h2AF, 1'b1, 1'b0);
		conv(32'h30, 32'hAB, 1'b0, 1'b0);
		t_clk(4);
		wr(ADDR_INPUT, 32'h02010503, RESP_OKAY);
		conv(32'h1, 32'hABC, 1'b1, 1'b0);
		cmp_w(word_t'({cfg.gain, cfg.neg_sel, cfg.pos_sel}), 32'h8A4);
		rc(ADDR_INPUT, 32'h02110503);
		wr(ADDR_WINHI, 32'hB00, RESP_OKAY);
		wr(ADDR_WIN, 32'h3, RESP_OKAY);
		conv(32'h4, 32'hABC, 1'b1, 1'b0);
		conv(32'h0, 32'hABC, 1'b1, 1'b1);
		wr(ADDR_CAL, 32'h00BC0800, RESP_OKAY);
		conv(32'h8, 32'hA00, 1'b1, 1'b0);
		finish_test();
	end
endmodule
